// ==== hw/gate_drive_host.sv ====
// host controller that drives a buck gate drive stage through its pins
`timescale 1ns/10ps
module gate_drive_host
    import gate_drive_host_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register port
    input wire gate_drive_host_pkg::bus_req_type busReq,
    output logic [gate_drive_host_pkg::DATA_W-1:0] busRdata,
    // stage pins and supply monitor
    output gate_drive_host_pkg::stage_pins_type stagePins,
    input wire logic overtempFlag_n,
    input wire logic supplyOk,
    // interrupt
    output logic irq
);
    import gate_drive_host_pkg::*;

    typedef struct packed {
        phase_type phase;
        logic [1:0] flagSync;
        logic [1:0] supplySync;
        logic alarm;
        logic supplyGood;
        logic run;
        logic diodeMode;
        logic [DATA_W-1:0] period;
        logic [DATA_W-1:0] target;
        logic [DATA_W-1:0] step;
        logic [DATA_W-1:0] cnt;
        logic [DATA_W-1:0] duty;
        logic [WAIT_W-1:0] settle;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic [DATA_W-1:0] rdata;
        logic irq;
        stage_pins_type pins;
    } state_type;

    // refused at elaboration, not at run time
    if (ENABLE_SETTLE_CYC >= (1 << WAIT_W)) begin : g_settle_check
        $error("settle count does not fit its counter");
    end

    state_type st_ff;
    state_type nxt_st;

    function automatic logic hit(input bus_req_type req, input logic [ADDR_W-1:0] a);
        hit = req.wr && (req.addr == a);
    endfunction

    logic [DATA_W:0] rampSum;
    logic periodEnd;
    logic stopReq;
    logic [EVT_W-1:0] events;
    logic [DATA_W-1:0] clampTarget;

    always_comb begin
        nxt_st = st_ff;
        events = '0;
        rampSum = {1'b0, st_ff.duty} + {1'b0, st_ff.step};
        clampTarget = (st_ff.target > st_ff.period) ? st_ff.period : st_ff.target;
        periodEnd = (st_ff.period == DATA_ZERO) || (st_ff.cnt >= st_ff.period - 16'h0001);

        // pin inputs cross in through three flops: two sync stages, then the alarm and supplyGood registers
        nxt_st.flagSync = {st_ff.flagSync[0], ~overtempFlag_n};
        nxt_st.supplySync = {st_ff.supplySync[0], supplyOk};
        nxt_st.alarm = st_ff.flagSync[1];
        nxt_st.supplyGood = st_ff.supplySync[1];
        if (nxt_st.alarm && !st_ff.alarm) begin
            events[EVT_ALARM_SET] = 1'b1;
        end
        if (!nxt_st.alarm && st_ff.alarm) begin
            events[EVT_ALARM_CLR] = 1'b1;
        end
        // lockout in the stage shows up as loss of the supply monitor
        if (!nxt_st.supplyGood && st_ff.supplyGood) begin
            events[EVT_SUPPLY_LOST] = 1'b1;
        end

        // register writes
        if (hit(busReq, REG_CTRL)) begin
            nxt_st.run = busReq.wdata[CTRL_RUN_BIT];
            nxt_st.diodeMode = busReq.wdata[CTRL_DIODE_BIT];
        end
        if (hit(busReq, REG_PERIOD)) begin
            nxt_st.period = busReq.wdata;
        end
        if (hit(busReq, REG_DUTY)) begin
            nxt_st.target = busReq.wdata;
        end
        if (hit(busReq, REG_STEP)) begin
            nxt_st.step = busReq.wdata;
        end
        if (hit(busReq, REG_MASK)) begin
            nxt_st.mask = busReq.wdata[EVT_W-1:0];
        end

        // pwm period counter runs only while pwm is driven
        if (st_ff.phase == ST_RAMP || st_ff.phase == ST_RUN) begin
            nxt_st.cnt = periodEnd ? DATA_ZERO : st_ff.cnt + 16'h0001;
        end else begin
            nxt_st.cnt = DATA_ZERO;
        end

        // alarm or supply loss stops everything without waiting for software
        stopReq = !st_ff.run || !st_ff.supplyGood || st_ff.alarm;

        unique case (st_ff.phase)
            ST_IDLE: begin
                nxt_st.duty = DATA_ZERO;
                nxt_st.settle = '0;
                if (!stopReq) begin
                    nxt_st.phase = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                nxt_st.settle = st_ff.settle + 8'h01;
                if (stopReq) begin
                    nxt_st.phase = ST_IDLE;
                end else if (st_ff.settle >= WAIT_W'(ENABLE_SETTLE_CYC - 1)) begin
                    nxt_st.phase = ST_RAMP;
                    nxt_st.duty = DATA_ZERO;
                end
            end
            ST_RAMP: begin
                if (stopReq) begin
                    nxt_st.phase = ST_IDLE;
                end else if (periodEnd) begin
                    // ramp one step per pwm period up to the target
                    if (rampSum >= {1'b0, clampTarget}) begin
                        nxt_st.duty = clampTarget;
                        nxt_st.phase = ST_RUN;
                        events[EVT_RAMP_DONE] = 1'b1;
                    end else begin
                        nxt_st.duty = rampSum[DATA_W-1:0];
                    end
                end
            end
            ST_RUN: begin
                if (stopReq) begin
                    nxt_st.phase = ST_IDLE;
                end else if (periodEnd) begin
                    // new duty takes effect only on a period boundary
                    nxt_st.duty = clampTarget;
                end
            end
        endcase

        // pins: disable first, pwm released outside ramp and run
        nxt_st.pins.outputDisable_n = (nxt_st.phase != ST_IDLE);
        nxt_st.pins.diodeEmulationSelect_n = ~nxt_st.diodeMode;
        if (nxt_st.phase == ST_RAMP || nxt_st.phase == ST_RUN) begin
            nxt_st.pins.pwmOe_n = 1'b0;
            nxt_st.pins.pwmOut = (nxt_st.cnt < nxt_st.duty);
        end else begin
            // released pin floats to mid-level, which the stage reads as both off after its 170 ns hold-off
            nxt_st.pins.pwmOe_n = 1'b1;
            nxt_st.pins.pwmOut = 1'b0;
        end

        // sticky status, a new event wins over a clear in the same cycle
        if (hit(busReq, REG_STATUS)) begin
            nxt_st.status = (st_ff.status & ~busReq.wdata[EVT_W-1:0]) | events;
        end else begin
            nxt_st.status = st_ff.status | events;
        end
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);

        // read data in the cycle after the strobe only
        nxt_st.rdata = DATA_ZERO;
        if (busReq.rd) begin
            unique case (busReq.addr)
                REG_CTRL: nxt_st.rdata = {14'h0000, st_ff.diodeMode, st_ff.run};
                REG_PERIOD: nxt_st.rdata = st_ff.period;
                REG_DUTY: nxt_st.rdata = st_ff.target;
                REG_STEP: nxt_st.rdata = st_ff.step;
                REG_STATUS: nxt_st.rdata = {12'h000, st_ff.status};
                REG_MASK: nxt_st.rdata = {12'h000, st_ff.mask};
                REG_STATE: nxt_st.rdata = {st_ff.duty[7:0], st_ff.supplyGood, st_ff.alarm,
                    2'b00, st_ff.phase};
                default: nxt_st.rdata = DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{phase: ST_IDLE, period: PERIOD_RST, step: STEP_RST,
                pins: '{pwmOut: 1'b0, pwmOe_n: 1'b1, outputDisable_n: 1'b0,
                diodeEmulationSelect_n: 1'b1}, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busRdata = st_ff.rdata;
    assign stagePins = st_ff.pins;
    assign irq = st_ff.irq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    property p_pwm_needs_enable;
        // pins follow the phase one edge behind the synchronised supply flag
        !stagePins.pwmOe_n |-> stagePins.outputDisable_n && $past(st_ff.supplyGood);
    endproperty
    a_pwm_needs_enable: assert property (p_pwm_needs_enable) else $error("pwm driven while stage disabled or unpowered");

    property p_pwm_after_settle;
        $fell(stagePins.pwmOe_n) |-> $past(st_ff.phase == ST_SETTLE)
            && $past(stagePins.outputDisable_n, 25);
    endproperty
    a_pwm_after_settle: assert property (p_pwm_after_settle) else $error("pwm started before settle time");

    property p_release_when_disabled;
        !stagePins.outputDisable_n |-> stagePins.pwmOe_n;
    endproperty
    a_release_when_disabled: assert property (p_release_when_disabled) else $error("pwm driven while stage disabled");

    property p_ramp_from_zero;
        $fell(stagePins.pwmOe_n) |-> st_ff.duty == DATA_ZERO && !stagePins.pwmOut;
    endproperty
    a_ramp_from_zero: assert property (p_ramp_from_zero) else $error("pwm start not at zero duty");

    property p_alarm_shutdown;
        $rose(st_ff.alarm) |-> ##[1:2] (!stagePins.outputDisable_n && stagePins.pwmOe_n);
    endproperty
    a_alarm_shutdown: assert property (p_alarm_shutdown) else $error("no shutdown after alarm");

    property p_flag_seen;
        (!overtempFlag_n) [*4] |-> st_ff.alarm;
    endproperty
    a_flag_seen: assert property (p_flag_seen) else $error("low alarm flag not taken");
endmodule

// ==== hw/gate_drive_host_pkg.sv ====
// shared constants and carrier types of the gate drive host controller
package gate_drive_host_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int CLK_PERIOD_NS = 40;
    // settle time between enabling the stage and the first pwm edge
    localparam int ENABLE_SETTLE_NS = 1000;
    localparam int ENABLE_SETTLE_CYC = (ENABLE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W = 8;
    // register indices
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h1;
    localparam logic [ADDR_W-1:0] REG_DUTY = 4'h2;
    localparam logic [ADDR_W-1:0] REG_STEP = 4'h3;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_MASK = 4'h5;
    localparam logic [ADDR_W-1:0] REG_STATE = 4'h6;
    // control fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_DIODE_BIT = 1;
    // status event fields
    localparam int EVT_W = 4;
    localparam int EVT_ALARM_SET = 0;
    localparam int EVT_ALARM_CLR = 1;
    localparam int EVT_SUPPLY_LOST = 2;
    localparam int EVT_RAMP_DONE = 3;
    // reset values
    localparam logic [DATA_W-1:0] PERIOD_RST = 16'h0064;
    localparam logic [DATA_W-1:0] STEP_RST = 16'h0001;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETTLE = 4'h2,
        ST_RAMP = 4'h4,
        ST_RUN = 4'h8
    } phase_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    // pins toward the power stage
    typedef struct packed {
        logic pwmOut;
        logic pwmOe_n;
        logic outputDisable_n;
        logic diodeEmulationSelect_n;
    } stage_pins_type;
endpackage

// ==== verification/buck_stage_model.sv ====
// behavioural model of the buck gate drive stage
`timescale 1ns/10ps
module buck_stage_model
    import gate_drive_host_pkg::*;
(
    // pins from the host
    input wire gate_drive_host_pkg::stage_pins_type stagePins,
    // environment set by the bench
    input wire logic [15:0] supplyMv,
    input wire logic [7:0] tempC,
    // flag, supply monitor, gates
    output logic overtempFlag_n,
    output logic supplyOk,
    output logic hsGate,
    output logic lsGate
);
    logic good = 1'b0;
    logic alarm = 1'b0;
    logic triHeld = 1'b1;
    logic pwmSeen = 1'b0;
    logic hsWant, lsWant;
    //////////////////////////////
    // evaluated at time zero too: the bench sets its first levels by declaration
    always begin
        if (supplyMv >= 16'h0DAC) good = 1'b1;
        else if (supplyMv < 16'h0B86) good = 1'b0;
        @(supplyMv);
    end
    always begin
        if (tempC > 8'h96) alarm = 1'b1;
        else if (tempC <= 8'h87) alarm = 1'b0;
        @(tempC);
    end
    // flag driven push-pull here: low on alarm, driven high otherwise
    assign overtempFlag_n = alarm ? 1'b0 : 1'b1;
    assign supplyOk = good;
    // a released pin keeps the last driven level until hold-off ends
    always @(stagePins.pwmOut, stagePins.pwmOe_n) begin
        if (!stagePins.pwmOe_n) pwmSeen <= #35 stagePins.pwmOut;
    end
    always begin
        wait (stagePins.pwmOe_n === 1'b1);
        #170;
        if (stagePins.pwmOe_n === 1'b1) triHeld = 1'b1;
        wait (stagePins.pwmOe_n === 1'b0);
        #35;
        triHeld = 1'b0;
    end
    assign hsWant = good & stagePins.outputDisable_n & !triHeld & pwmSeen;
    // diode emulation: low side simply stays off
    assign lsWant = good & stagePins.outputDisable_n & !triHeld & !pwmSeen
        & stagePins.diodeEmulationSelect_n;
    // each gate turns on only after the other has gone off
    always #1 begin
        hsGate <= hsWant & !lsGate;
        lsGate <= lsWant & !hsGate;
    end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench of the gate drive host with the stage model
`timescale 1ns/10ps
module tb_top;
    import gate_drive_host_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    bus_req_type busReq = '0;
    logic [DATA_W-1:0] busRdata;
    stage_pins_type stagePins;
    logic overtempFlag_n, supplyOk, irq, hsGate, lsGate;
    logic [15:0] supplyMv = 16'h1388;
    logic [7:0] tempC = 8'h19;
    logic lsSeen = 1'b0;
    logic hsSeen = 1'b0;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 32'h2652D95B;
    gate_drive_host gate_drive_host_inst (.clk_sys(clk_sys), .nrst(nrst), .busReq(busReq),
        .busRdata(busRdata), .stagePins(stagePins), .overtempFlag_n(overtempFlag_n),
        .supplyOk(supplyOk), .irq(irq));
    buck_stage_model buck_stage_model_inst (.stagePins(stagePins), .supplyMv(supplyMv),
        .tempC(tempC), .overtempFlag_n(overtempFlag_n), .supplyOk(supplyOk),
        .hsGate(hsGate), .lsGate(lsGate));
    always #20 clk_sys = ~clk_sys;
    always @(posedge lsGate) lsSeen = 1'b1;
    always @(posedge hsGate) hsSeen = 1'b1;
    //////////////////////////////
    function automatic logic [15:0] st(logic g, logic a, phase_type p);
        return {8'h00, g, a, 2'b00, p};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys) busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys) busReq <= '{a, d, 1'b0, 1'b0};
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys) busReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_sys) busReq <= '{a, 16'h0000, 1'b0, 1'b0};
        #1 d = busRdata;
    endtask
    task automatic wait_phase(input phase_type ph);
        logic [15:0] v;
        for (int i = 0; i < 3000 && v[3:0] !== ph; i++) rd(REG_STATE, v);
        chk(16'(v[3:0]), 16'(ph));
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        logic [15:0] v, per, duty;
        int hi;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        idle(4);
        chk(16'(stagePins), 16'h0005);
        rd(REG_PERIOD, v);
        chk(v, PERIOD_RST);
        rd(REG_STEP, v);
        chk(v, STEP_RST);
        rd(4'hF, v);
        chk(v, DATA_ZERO);
        rd(REG_STATE, v);
        chk(v, st(1'b1, 1'b0, ST_IDLE));
        wr(REG_MASK, 16'h000F);
        for (int m = 0; m < 2; m++) begin
            per = 16'(32'h10 + ($random(seed) & 32'hF));
            duty = (m == 1) ? per : 16'(32'h3 + ($random(seed) & 32'h7));
            wr(REG_PERIOD, per);
            wr(REG_DUTY, duty);
            wr(REG_STEP, 16'(32'h1 + ($random(seed) & 32'h3)));
            wr(REG_CTRL, 16'(2 * m + 1));
            idle(3);
            chk(16'(stagePins), 16'(7 - m));
            idle(20);
            chk(16'(stagePins.pwmOe_n), 16'h0001);
            lsSeen = 1'b0;
            hsSeen = 1'b0;
            wait_phase(ST_RAMP);
            rd(REG_STATE, v);
            chk(16'(v[15:8]), 16'h0000);
            wait_phase(ST_RUN);
            rd(REG_STATUS, v);
            chk(v & 16'h0008, 16'h0008);
            chk(16'(irq), 16'h0001);
            hi = 0;
            repeat (2 * per) @(negedge clk_sys) hi += stagePins.pwmOut;
            chk(16'(hi), 16'(2 * duty));
            chk(16'(lsSeen), 16'(1 - m));
            chk(16'(hsSeen), 16'h0001);
            wr(REG_STATUS, 16'h000F);
            wr(REG_CTRL, 16'h0000);
            idle(1);
            chk(16'(irq), 16'h0000);
            wait_phase(ST_IDLE);
        end
        wr(REG_CTRL, 16'h0001);
        wait_phase(ST_RAMP);
        @(posedge clk_sys) tempC <= 8'hA0;
        idle(8);
        chk(16'({stagePins.pwmOe_n, stagePins.outputDisable_n}), 16'h0002);
        chk(16'({hsGate, lsGate}), 16'h0000);
        rd(REG_STATUS, v);
        chk(v & 16'h0001, 16'h0001);
        chk(16'(irq), 16'h0001);
        wr(REG_MASK, 16'h0000);
        idle(1);
        chk(16'(irq), 16'h0000);
        wr(REG_MASK, 16'h000F);
        wr(REG_STATUS, 16'h000F);
        @(posedge clk_sys) tempC <= 8'h8C;
        idle(8);
        rd(REG_STATE, v);
        chk(16'(v[7:0]), st(1'b1, 1'b1, ST_IDLE));
        @(posedge clk_sys) tempC <= 8'h80;
        idle(8);
        rd(REG_STATUS, v);
        chk(v & 16'h0003, 16'h0002);
        wait_phase(ST_RAMP);
        @(posedge clk_sys) supplyMv <= 16'h0C80;
        idle(8);
        rd(REG_STATE, v);
        chk(16'(v[7]), 16'h0001);
        @(posedge clk_sys) supplyMv <= 16'h0B54;
        idle(8);
        chk(16'({stagePins.pwmOe_n, stagePins.outputDisable_n}), 16'h0002);
        rd(REG_STATUS, v);
        chk(v & 16'h0004, 16'h0004);
        @(posedge clk_sys) supplyMv <= 16'h0D48;
        idle(8);
        rd(REG_STATE, v);
        chk(16'(v[7:0]), st(1'b0, 1'b0, ST_IDLE));
        @(posedge clk_sys) supplyMv <= 16'h0E10;
        wait_phase(ST_RAMP);
        complete_run;
    end
    initial begin
        #1000000;
        error_cnt++;
        complete_run;
    end
endmodule
